/* hw/ebt_timer.sv */
// 8-bit interval timer with preload, clock selector, start-bit detection and bit latches.
// Assumes APB from software, and all clock sources sampled synchronously to mclk.
`timescale 1ns/1ns
// Functional notes
// - 8-bit up-counter with 8-bit preload register.
// - 8-bit control register governs this block.
// - Two bits pick one of four count clocks.
// - Counter write loads preload into counter.
// - Preload readable, writable, buffers next value.
// - Enabled counter increments on selected clock edge.
// - Edge detect holds counter until start edge.
// - First interval after start samples receive input.
// - Carry-out clocks both receive and transmit latches.
// - Transmit latch shifts one software bit per interval.
// - Auxiliary clock is crystal; main is multiple.
module ebt_timer
  import ebt_pkg::*;
(
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   srst,
  // APB slave
  input  wire logic   psel,
  input  wire logic   penable,
  input  wire logic   pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic        pready,
  output logic        pslverr,
  output logic [31:0] prdata,
  // Clock sources and serial pins
  input  wire logic   auxClkTick,
  input  wire logic   external_timer_input_pin,
  input  wire logic   rxIn,
  output logic        txOut,
  output logic        carryOut
);

  ebt_apb_req_t req;
  logic [7:0]   ctrl_q;
  logic [7:0]   preload_q;
  logic [7:0]   count_q;
  logic [7:0]   count_d;
  logic         txNext_q;
  logic         rxLatch_q;
  logic         txLatch_q;
  logic         carry_q;
  logic         ready_q;
  logic         err_q;
  logic [31:0]  rdata_q;
  ebt_state_t   state_q;
  ebt_clksel_t  clkSel;
  logic         wrCounter;
  logic         accessNow;
  logic         pinRise;
  logic         mainPin;
  logic         mainPinRise;
  logic         tick;
  logic         rollover;
  logic         running;
  logic         firstDone_q;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Every access answers in the cycle after its first access cycle; the ready flop marks the answer cycle.
  assign accessNow = req.psel & req.penable & ~ready_q;
  assign wrCounter = accessNow & req.pwrite & (req.paddr == EBT_ADDR_COUNTER);

  // The external pin is seen as rising edges on mclk; the main-clock-and-pin gate is seen as the pin level.
  // The gated source is just the pin level, since mclk itself is always high at its own edge.
  assign mainPin = external_timer_input_pin;

  ebt_edge_det uPinEdge (
    .mclk  (mclk),
    .srst  (srst),
    .level (external_timer_input_pin),
    .rise  (pinRise),
    .fall  ()
  );

  logic rxFall;

  ebt_edge_det uRxEdge (
    .mclk  (mclk),
    .srst  (srst),
    .level (rxIn),
    .rise  (),
    .fall  (rxFall)
  );

  assign mainPinRise = mainPin;

  // Auxiliary clock arrives as a one-cycle tick per crystal period, a whole fraction of mclk.
  assign clkSel = ebt_clksel_t'(ctrl_q[EBT_CTRL_SEL_HI:EBT_CTRL_SEL_LO]);
  always_comb begin
    case (clkSel)
      EBT_CLK_MAIN:    tick = 1'b1;
      EBT_CLK_AUX:     tick = auxClkTick;
      EBT_CLK_PIN:     tick = pinRise;
      default:         tick = mainPinRise;
    endcase
  end

  // Arming needs a cycle to reach the wait state, so the edge enable alone already stops the count.
  assign running  = ctrl_q[EBT_CTRL_ENABLE] &
                    ((state_q == EBT_RUN_COUNT) | ((state_q == EBT_RUN_FREE) & ~ctrl_q[EBT_CTRL_EDGE_EN]));
  assign rollover = running & tick & (count_q == EBT_COUNT_ONES);

  // Control register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= EBT_CTRL_RESET;
    end else if (accessNow && req.pwrite && req.paddr == EBT_ADDR_CTRL) begin
      ctrl_q <= req.pwdata[7:0];
    end
  end

  // Preload takes a new value at any time; the counter copies it only on a counter write.
  always_ff @(posedge mclk) begin
    if (srst) begin
      preload_q <= EBT_PRELOAD_RESET;
    end else if (accessNow && req.pwrite && req.paddr == EBT_ADDR_PRELOAD) begin
      preload_q <= req.pwdata[7:0];
    end
  end

  // Counter: load wins over counting in the same cycle.
  always_comb begin
    count_d = count_q;
    if (wrCounter) begin
      count_d = preload_q;
    end else if (running && tick) begin
      count_d = count_q + EBT_COUNT_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      count_q <= EBT_COUNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // Start-bit detection: wait for a falling edge on the receive line, then count.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q     <= EBT_RUN_FREE;
      firstDone_q <= 1'b0;
    end else begin
      case (state_q)
        EBT_RUN_FREE: begin
          if (ctrl_q[EBT_CTRL_EDGE_EN]) begin
            state_q <= EBT_RUN_WAIT;
          end
        end
        EBT_RUN_WAIT: begin
          if (!ctrl_q[EBT_CTRL_EDGE_EN]) begin
            state_q <= EBT_RUN_FREE;
          end else if (rxFall) begin
            state_q     <= EBT_RUN_COUNT;
            firstDone_q <= 1'b0;
          end
        end
        default: begin
          if (!ctrl_q[EBT_CTRL_EDGE_EN]) begin
            state_q <= EBT_RUN_FREE;
          end else if (rollover) begin
            firstDone_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // Carry is a one-cycle pulse at the wrap from all ones to zero.
  always_ff @(posedge mclk) begin
    if (srst) begin
      carry_q <= 1'b0;
    end else begin
      carry_q <= rollover & ~wrCounter;
    end
  end

  // Both bit latches move only on the carry; software stages the next transmit bit in between.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxLatch_q <= 1'b0;
      txLatch_q <= 1'b1;
    end else if (rollover && !wrCounter) begin
      rxLatch_q <= rxIn;
      txLatch_q <= txNext_q;
    end
  end

  // Staged transmit bit; the idle line level is high, as an asynchronous link expects.
  always_ff @(posedge mclk) begin
    if (srst) begin
      txNext_q <= 1'b1;
    end else if (accessNow && req.pwrite && req.paddr == EBT_ADDR_TXBIT) begin
      txNext_q <= req.pwdata[0];
    end
  end

  assign txOut    = txLatch_q;
  assign carryOut = carry_q;

  // APB answer: one wait state so read data leaves a flop.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= EBT_READ_ZERO;
    end else begin
      ready_q <= accessNow;
      err_q   <= 1'b0;
      rdata_q <= EBT_READ_ZERO;
      if (accessNow) begin
        if (req.paddr == EBT_ADDR_CTRL) begin
          rdata_q[7:0] <= ctrl_q;
        end else if (req.paddr == EBT_ADDR_PRELOAD) begin
          rdata_q[7:0] <= preload_q;
        end else if (req.paddr == EBT_ADDR_COUNTER) begin
          rdata_q[7:0] <= count_q;
        end else if (req.paddr == EBT_ADDR_STATUS) begin
          rdata_q[EBT_STAT_RXBIT] <= rxLatch_q;
          rdata_q[EBT_STAT_TXBIT] <= txLatch_q;
          rdata_q[EBT_STAT_ARMED] <= (state_q == EBT_RUN_WAIT);
          rdata_q[EBT_STAT_CARRY] <= firstDone_q;
        end else if (req.paddr == EBT_ADDR_TXBIT) begin
          rdata_q[0] <= txNext_q;
        end else begin
          err_q <= 1'b1;
        end
      end
    end
  end

  assign pready  = ready_q;
  assign pslverr = err_q;
  assign prdata  = rdata_q;

endmodule

/* shared/ebt_pkg.sv */
// Package for the 8-bit timer with serial assist: register map, control fields, states.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package ebt_pkg;

  localparam logic [7:0] EBT_ADDR_CTRL    = 8'h00;
  localparam logic [7:0] EBT_ADDR_PRELOAD = 8'h04;
  localparam logic [7:0] EBT_ADDR_COUNTER = 8'h08;
  localparam logic [7:0] EBT_ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] EBT_ADDR_TXBIT   = 8'h10;

  localparam int EBT_CTRL_SEL_LO   = 0;
  localparam int EBT_CTRL_SEL_HI   = 1;
  localparam int EBT_CTRL_ENABLE   = 2;
  localparam int EBT_CTRL_EDGE_EN  = 3;

  localparam logic [7:0]  EBT_CTRL_RESET    = 8'h00;
  localparam logic [7:0]  EBT_PRELOAD_RESET = 8'h00;
  localparam logic [7:0]  EBT_COUNT_ONES    = 8'hFF;
  localparam logic [7:0]  EBT_COUNT_ZERO    = 8'h00;
  localparam logic [7:0]  EBT_COUNT_ONE     = 8'h01;
  localparam logic [31:0] EBT_READ_ZERO     = 32'h0000_0000;

  localparam int EBT_STAT_RXBIT  = 0;
  localparam int EBT_STAT_TXBIT  = 1;
  localparam int EBT_STAT_ARMED  = 2;
  localparam int EBT_STAT_CARRY  = 3;

  typedef enum logic [1:0] {
    EBT_CLK_MAIN    = 2'b00,
    EBT_CLK_AUX     = 2'b01,
    EBT_CLK_PIN     = 2'b10,
    EBT_CLK_MAINPIN = 2'b11
  } ebt_clksel_t;

  typedef enum logic [1:0] {
    EBT_RUN_FREE  = 2'b00,
    EBT_RUN_WAIT  = 2'b01,
    EBT_RUN_COUNT = 2'b10
  } ebt_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ebt_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ebt_apb_rsp_t;

endpackage

/* hw/ebt_edge_det.sv */
// Rising- and falling-edge detector for a level sampled on mclk.
// Assumes the input is already synchronous to mclk.
`timescale 1ns/1ns
module ebt_edge_det
  import ebt_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Level in, pulse out
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

endmodule

/* tb/ebt_serial_peer.sv */
// Far-side model: serial line level, crystal tick and external pulse source.
// Assumes the bench sets the receive level; outputs are synchronous to mclk.
`timescale 1ns/1ns
module ebt_serial_peer (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Bench control and pins
  input  wire logic rxDrive,
  output logic      rxIn,
  output logic      auxClkTick,
  output logic      external_timer_input_pin
);
  logic [2:0] phaseQ;
  always_ff @(posedge mclk) begin
    if (srst) phaseQ <= 3'h0;
    else phaseQ <= phaseQ + 3'h1;
  end
  // Main clock is four times the crystal tick.
  assign auxClkTick = (phaseQ[1:0] == 2'h3);
  assign external_timer_input_pin = phaseQ[2];
  assign rxIn = rxDrive;
endmodule

/* tb/ebt_timer_checker.sv */
// Port checker for the timer: bus handshake, carry pulse and transmit line.
// Assumes it is bound to the timer top with ports of the same names.
`timescale 1ns/1ns
module ebt_timer_checker
  import ebt_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        txOut,
  input wire logic        carryOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  access_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable)) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  unmapped_err_a: assert property (pready && (paddr > EBT_ADDR_TXBIT || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == EBT_READ_ZERO) else $error("unmapped taken");
  mapped_ok_a: assert property (pready && paddr <= EBT_ADDR_TXBIT && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped refused");
  idle_rdata_a: assert property (!pready |-> prdata == EBT_READ_ZERO) else $error("data outside answer");
  carry_pulse_a: assert property (carryOut |=> !carryOut) else $error("long carry");
  tx_carry_a: assert property ($changed(txOut) |-> carryOut) else $error("tx off carry");
  reset_out_a: assert property ($fell(srst) |-> !carryOut && txOut && !pready) else $error("reset outputs");
endmodule

/* tb/testbench.sv */
// Self-checking bench for the timer: registers, count clocks, bit latches.
// Assumes the timer and the far-side model in their own files.
`timescale 1ns/1ns
module testbench
  import ebt_pkg::*;
;
  logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rxDrive = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, auxClkTick, external_timer_input_pin, rxIn, txOut, carryOut;
  int n_mismatch = 0, total_checks = 0;
  ebt_timer dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .auxClkTick, .external_timer_input_pin, .rxIn, .txOut, .carryOut);
  ebt_serial_peer peer (.mclk, .srst, .rxDrive, .rxIn, .auxClkTick, .external_timer_input_pin);
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask
  task automatic wait_carry(output int n);
    n = 0;
    do begin @(negedge mclk); n++; end while (carryOut !== 1'b1 && n < 5000);
    if (carryOut !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t no carry seen", $time);
    end
  endtask
  task automatic reset_and_unmapped();
    logic [31:0] r; logic e;
    rd(EBT_ADDR_CTRL, 32'h0000_0000);
    rd(EBT_ADDR_PRELOAD, 32'h0000_0000);
    rd(EBT_ADDR_TXBIT, 32'h0000_0001);
    apb(1'b1, 8'h20, 32'h0000_00FF, r, e);
    chk(32'(e), 32'h0000_0001);
    rd(EBT_ADDR_CTRL, 32'h0000_0000);
  endtask
  task automatic preload_load();
    wr(EBT_ADDR_PRELOAD, 32'h0000_00A5);
    rd(EBT_ADDR_PRELOAD, 32'h0000_00A5);
    wr(EBT_ADDR_COUNTER, 32'h0000_0000);
    wr(EBT_ADDR_PRELOAD, 32'h0000_003C);
    rd(EBT_ADDR_COUNTER, 32'h0000_00A5);
    rd(EBT_ADDR_PRELOAD, 32'h0000_003C);
  endtask
  task automatic clock_modes();
    int per [4] = '{256, 1024, 2048, 512};
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(EBT_ADDR_CTRL, 32'(4 + s));
      wait_carry(n);
      wait_carry(n);
      chk(32'(n), 32'(per[s]));
    end
  endtask
  task automatic tx_bits();
    int n;
    wr(EBT_ADDR_CTRL, 32'h0000_0004);
    for (int b = 0; b < 2; b++) begin
      wr(EBT_ADDR_TXBIT, 32'(b));
      wait_carry(n);
      chk(32'(txOut), 32'(b));
    end
  endtask
  task automatic start_bit();
    int n;
    wr(EBT_ADDR_CTRL, 32'h0000_000C);
    wr(EBT_ADDR_PRELOAD, 32'h0000_0080);
    wr(EBT_ADDR_COUNTER, 32'h0000_0000);
    rd(EBT_ADDR_COUNTER, 32'h0000_0080);
    @(posedge mclk);
    rxDrive <= 1'b0;
    wait_carry(n);
    chk(32'(n), 32'h0000_0082);
    rd(EBT_ADDR_STATUS, 32'h0000_000A);
    rxDrive <= 1'b1;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    reset_and_unmapped();
    preload_load();
    clock_modes();
    tx_bits();
    start_bit();
    close_out();
  end
  // Whole run needs about ten thousand cycles; twice that means a hang.
  initial begin
    #800000;
    n_mismatch++;
    close_out();
  end
endmodule
bind ebt_timer ebt_timer_checker chk_i (.mclk, .srst, .psel, .penable, .paddr, .pready, .pslverr, .prdata,
  .txOut, .carryOut);
